// ---- ctrl_current_tracker.sv ----
// Purpose: control list current pointer and its end-of-list reload
// Assumes: list events arrive on i_clk from the list processor
// Notes: end-of-list beats descriptor advance beats software write
`timescale 1ns/1ns
`include "ohci_ptr_regs.svh"

module ctrl_current_tracker
    import ohci_ptr_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // list processor
    input wire ptr_type i_head,
    input wire logic i_ed_done,
    input wire ptr_type i_next,
    input wire logic i_list_end,
    input wire logic i_clf,
    input wire logic i_enable,
    // software write
    input wire logic i_sw_wr,
    input wire ptr_type i_sw_data,
    // state
    output ptr_type o_current,
    output logic o_clf_clear,
    output logic o_empty
);

    cur_state_type st_ff;
    cur_state_type nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.clf_clear = 1'b0;
        if (i_list_end) begin
            if (i_clf) begin
                nxt_st.current = i_head; // see RULE9
                nxt_st.clf_clear = 1'b1; // see RULE9
            end
        end else if (i_ed_done) begin
            nxt_st.current = i_next; // see RULE6
        end else if (i_sw_wr && !i_enable) begin
            nxt_st.current = i_sw_data; // see RULE10
        end
        // zero pointer marks end of list
        nxt_st.empty = (nxt_st.current == `PTR_RESET); // see RULE11
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_ff <= '{current: `PTR_RESET, clf_clear: 1'b0,
                       empty: 1'b1}; // see RULE11
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_current = st_ff.current;
    assign o_clf_clear = st_ff.clf_clear;
    assign o_empty = st_ff.empty;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    property p_reload;
        i_list_end && i_clf |=> o_current == $past(i_head) && o_clf_clear;
    endproperty
    a_reload: assert property (p_reload) // see RULE9
        else $error("end of list with filled bit did not reload");

    property p_no_clf;
        i_list_end && !i_clf |=> $stable(o_current) && !o_clf_clear;
    endproperty
    a_no_clf: assert property (p_no_clf) // see RULE8
        else $error("end of list without filled bit changed pointer");

    property p_advance;
        i_ed_done && !i_list_end |=> o_current == $past(i_next);
    endproperty
    a_advance: assert property (p_advance) // see RULE6
        else $error("current pointer did not advance");

    property p_resume;
        !i_list_end && !i_ed_done && !i_sw_wr |=> $stable(o_current);
    endproperty
    a_resume: assert property (p_resume) // see RULE7
        else $error("current pointer moved without cause");

    property p_empty;
        o_empty == (o_current == `PTR_RESET);
    endproperty
    a_empty: assert property (p_empty) // see RULE11
        else $error("empty flag disagrees with zero pointer");

    c_reload: cover property (i_list_end && i_clf ##1 o_clf_clear);

endmodule // ctrl_current_tracker

// ---- hcd_side_model.sv ----
// Purpose: driver-side owner of the filled and enable bits
// Assumes: filled bit set by a software pulse, cleared on request
// Notes: all other command and control bits read zero
`timescale 1ns/1ns

module hcd_side_model (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // software intent
    input wire logic i_set_filled,
    input wire logic i_enable,
    // request from the block
    input wire logic i_clf_clear,
    // registers seen by the block
    output logic [31:0] o_command_status_reg,
    output logic [31:0] o_control_reg
);
    logic filled_ff;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            filled_ff <= 1'b0;
        end else if (i_clf_clear) begin
            filled_ff <= 1'b0;
        end else if (i_set_filled) begin
            filled_ff <= 1'b1;
        end
    end

    assign o_command_status_reg = {30'h0, filled_ff, 1'b0};
    assign o_control_reg = {27'h0, i_enable, 4'h0};
endmodule // hcd_side_model

// ---- ohci_ctrl_bulk_ptrs.sv ----
// Purpose: control and bulk list pointer registers of the host controller
// Assumes: one-cycle register access strobe on i_clk, answer one cycle on
// Notes: unmapped offsets read zero and ignore writes
`timescale 1ns/1ns
`include "ohci_ptr_regs.svh"

// Overview of operation
// RULE1 - head 20h, current 24h, bulk head 28h
// RULE2 - control head holds address in bits 31:4
// RULE3 - control walk starts at control head
// RULE4 - initialization loads both heads from shared area
// RULE5 - control current holds served descriptor address
// RULE6 - advance current after serving descriptor
// RULE7 - each frame resumes where last stopped
// RULE8 - end of list, filled clear: do nothing
// RULE9 - filled set: copy head, clear bit
// RULE10 - software rewrites current only when disabled
// RULE11 - current resets zero; zero ends list
// RULE12 - bulk head read-write, bits 31:4, reset zero
// RULE13 - bulk walk starts at bulk head
// RULE14 - software writes reserved bulk bits zero
// RULE15 - reserved bits 3:0 always read zero
module ohci_ctrl_bulk_ptrs
    import ohci_ptr_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // memory window access
    input wire logic i_mem_sel,
    input wire logic i_mem_wr,
    input wire logic [ADDR_W-1:0] i_mem_addr,
    input wire logic [31:0] i_mem_wdata,
    output logic [31:0] o_mem_rdata,
    output logic o_mem_ack,
    // initialization from the shared area
    input wire logic i_init_load,
    input wire logic [31:0] i_hcca_ctrl_head,
    input wire logic [31:0] i_hcca_bulk_head,
    // list processor
    input wire logic i_ed_done,
    input wire logic [31:0] i_next_ed,
    input wire logic i_list_end,
    input wire logic [31:0] i_command_status_reg,
    input wire logic [31:0] i_control_reg,
    // pointers toward the list processor
    output logic [31:0] o_ctrl_head_addr,
    output logic [31:0] o_ctrl_current_addr,
    output logic [31:0] o_bulk_head_addr,
    output logic o_ctrl_list_empty,
    output logic o_clf_clear
);

    // elaboration check: the register offsets need eight address bits
    if (ADDR_W < 8) begin : g_addr_check
        $error("ADDR_W must cover the 8-bit offsets");
    end

    ////////////////////////////////////////////////////////////////////////
    // offset decode

    function automatic reg_sel_type decode_sel(
        input logic [ADDR_W-1:0] addr
    );
        reg_sel_type sel;
        sel = SEL_NONE;
        if ((addr >> 8) == '0) begin
            unique case (addr[7:0])
                `OFS_CTRL_HEAD: sel = SEL_CTRL_HEAD; // see RULE1
                `OFS_CTRL_CURRENT: sel = SEL_CTRL_CURRENT; // see RULE1
                `OFS_BULK_HEAD: sel = SEL_BULK_HEAD; // see RULE1
                default: sel = SEL_NONE;
            endcase
        end
        return sel;
    endfunction

    function automatic logic [31:0] widen(input ptr_type p);
        return {p, `PTR_RSVD}; // see RULE15
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // state

    top_state_type st_ff;
    top_state_type nxt_st;
    reg_sel_type sel;
    logic rd_req;
    logic wr_req;
    logic control_list_filled;
    logic cle;
    ptr_type current;
    logic cur_clf_clear;
    logic cur_empty;

    assign sel = decode_sel(i_mem_addr);
    assign rd_req = i_mem_sel && !i_mem_wr;
    assign wr_req = i_mem_sel && i_mem_wr;
    assign control_list_filled = i_command_status_reg[`CLF_BIT]; // see RULE8
    assign cle = i_control_reg[`CLE_BIT]; // see RULE10

    ////////////////////////////////////////////////////////////////////////
    // control current pointer

    ctrl_current_tracker u_tracker (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_head(st_ff.ctrl_head),
        .i_ed_done(i_ed_done),
        .i_next(i_next_ed[`PTR_MSB:`PTR_LSB]), // see RULE5
        .i_list_end(i_list_end),
        .i_clf(control_list_filled),
        .i_enable(cle),
        .i_sw_wr(wr_req && sel == SEL_CTRL_CURRENT),
        .i_sw_data(i_mem_wdata[`PTR_MSB:`PTR_LSB]),
        .o_current(current),
        .o_clf_clear(cur_clf_clear),
        .o_empty(cur_empty)
    );

    ////////////////////////////////////////////////////////////////////////
    // register file and read path

    always_comb begin
        nxt_st = st_ff;
        nxt_st.ack = i_mem_sel;
        nxt_st.rdata = 32'h00000000;
        if (rd_req) begin
            unique case (sel)
                SEL_CTRL_HEAD: nxt_st.rdata = widen(st_ff.ctrl_head); // see RULE2
                SEL_CTRL_CURRENT: nxt_st.rdata = widen(current); // see RULE5
                SEL_BULK_HEAD: nxt_st.rdata = widen(st_ff.bulk_head); // see RULE12
                SEL_NONE: nxt_st.rdata = 32'h00000000;
            endcase
        end
        // low bits are dropped, so a nonzero reserved write is harmless
        if (wr_req && sel == SEL_BULK_HEAD) begin
            nxt_st.bulk_head = i_mem_wdata[`PTR_MSB:`PTR_LSB]; // see RULE14
        end
        // initialization wins over a software write in the same cycle
        if (i_init_load) begin
            nxt_st.ctrl_head =
                i_hcca_ctrl_head[`PTR_MSB:`PTR_LSB]; // see RULE4
            nxt_st.bulk_head =
                i_hcca_bulk_head[`PTR_MSB:`PTR_LSB]; // see RULE4
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_ff <= '{ctrl_head: `PTR_RESET, bulk_head: `PTR_RESET,
                       rdata: 32'h00000000, ack: 1'b0}; // see RULE12
        end else begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign o_mem_rdata = st_ff.rdata;
    assign o_mem_ack = st_ff.ack;
    assign o_ctrl_head_addr = widen(st_ff.ctrl_head); // see RULE3
    assign o_ctrl_current_addr = widen(current);
    assign o_bulk_head_addr = widen(st_ff.bulk_head); // see RULE13
    assign o_ctrl_list_empty = cur_empty;
    assign o_clf_clear = cur_clf_clear;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    property p_ack;
        i_mem_sel |=> o_mem_ack;
    endproperty
    a_ack: assert property (p_ack) // see RULE1
        else $error("access not answered next cycle");

    property p_ack_pulse;
        !i_mem_sel |=> !o_mem_ack;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) // see RULE1
        else $error("access answered without a request");

    property p_rd_head;
        rd_req && decode_sel(i_mem_addr) == SEL_CTRL_HEAD
            |=> o_mem_rdata == $past(o_ctrl_head_addr);
    endproperty
    a_rd_head: assert property (p_rd_head) // see RULE2
        else $error("control head read returned wrong value");

    property p_rd_current;
        rd_req && decode_sel(i_mem_addr) == SEL_CTRL_CURRENT
            |=> o_mem_rdata == $past(o_ctrl_current_addr);
    endproperty
    a_rd_current: assert property (p_rd_current) // see RULE5
        else $error("control current read returned wrong value");

    property p_unmapped;
        rd_req && decode_sel(i_mem_addr) == SEL_NONE |=> o_mem_rdata == '0;
    endproperty
    a_unmapped: assert property (p_unmapped) // see RULE1
        else $error("unmapped read returned nonzero");

    property p_rsvd;
        o_mem_rdata[3:0] == 4'h0 && o_ctrl_current_addr[3:0] == 4'h0;
    endproperty
    a_rsvd: assert property (p_rsvd) // see RULE15
        else $error("reserved low bits not zero");

    property p_bulk_wr;
        wr_req && decode_sel(i_mem_addr) == SEL_BULK_HEAD && !i_init_load
            |=> o_bulk_head_addr == {$past(i_mem_wdata[31:4]), 4'h0};
    endproperty
    a_bulk_wr: assert property (p_bulk_wr) // see RULE12
        else $error("bulk head write not stored");

    property p_head_ro;
        !i_init_load |=> $stable(o_ctrl_head_addr);
    endproperty
    a_head_ro: assert property (p_head_ro) // see RULE2
        else $error("control head changed outside initialization");

    property p_init;
        i_init_load |=>
            o_ctrl_head_addr == {$past(i_hcca_ctrl_head[31:4]), 4'h0} &&
            o_bulk_head_addr == {$past(i_hcca_bulk_head[31:4]), 4'h0};
    endproperty
    a_init: assert property (p_init) // see RULE4
        else $error("heads not loaded at initialization");

    property p_cur_protect;
        wr_req && decode_sel(i_mem_addr) == SEL_CTRL_CURRENT && cle &&
            !i_ed_done && !i_list_end |=> $stable(o_ctrl_current_addr);
    endproperty
    a_cur_protect: assert property (p_cur_protect) // see RULE10
        else $error("current pointer written while list enabled");

    property p_walk_start;
        i_list_end && control_list_filled && !i_init_load
            |=> o_ctrl_current_addr == o_ctrl_head_addr;
    endproperty
    a_walk_start: assert property (p_walk_start) // see RULE3
        else $error("control walk not restarted at head");

    c_rd_head: cover property (rd_req && sel == SEL_CTRL_HEAD ##1 o_mem_ack);
    c_bulk_wr: cover property (wr_req && sel == SEL_BULK_HEAD);
    c_init: cover property (i_init_load ##1 o_ctrl_head_addr != '0);
    c_end_empty: cover property (i_list_end && !control_list_filled);

endmodule // ohci_ctrl_bulk_ptrs

// ---- ohci_ptr_pkg.sv ----
// Purpose: types shared by the list pointer block
// Assumes: pointers are 16-byte aligned descriptor addresses
// Notes: constants live in ohci_ptr_regs.svh
package ohci_ptr_pkg;

    typedef logic [27:0] ptr_type;

    typedef enum logic [3:0] {
        SEL_NONE = 4'b0001,
        SEL_CTRL_HEAD = 4'b0010,
        SEL_CTRL_CURRENT = 4'b0100,
        SEL_BULK_HEAD = 4'b1000
    } reg_sel_type;

    typedef struct packed {
        ptr_type ctrl_head;
        ptr_type bulk_head;
        logic [31:0] rdata;
        logic ack;
    } top_state_type;

    typedef struct packed {
        ptr_type current;
        logic clf_clear;
        logic empty;
    } cur_state_type;

endpackage

// ---- ohci_ptr_regs.svh ----
// Purpose: offsets, field positions, reset values of the list pointers
// Assumes: byte offsets relative to the memory base address window
// Notes: definitions only
`ifndef OHCI_PTR_REGS_SVH
`define OHCI_PTR_REGS_SVH

// register offsets in the memory window
`define OFS_CTRL_HEAD 8'h20
`define OFS_CTRL_CURRENT 8'h24
`define OFS_BULK_HEAD 8'h28

// pointer field and reserved low bits
`define PTR_MSB 31
`define PTR_LSB 4
`define PTR_RSVD 4'h0
`define PTR_RESET 28'h0000000

// bits of neighbouring control registers
`define CLF_BIT 1
`define CLE_BIT 4

`endif

// ---- testbench.sv ----
// Purpose: register and list event checks of the pointer block
// Assumes: one-cycle access strobe, answer on the following edge
// Notes: expectations come from offsets and the 16-byte alignment
`timescale 1ns/1ns

module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic sel = 1'b0;
    logic wr = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic init = 1'b0;
    logic [31:0] hc_ctrl = 32'h0;
    logic [31:0] hc_bulk = 32'h0;
    logic done = 1'b0;
    logic [31:0] nxt = 32'h0;
    logic lend = 1'b0;
    logic set_f = 1'b0;
    logic en = 1'b0;
    logic [31:0] cmd, ctl, rdata, head, cur, bulk;
    logic ack, empty, clf_clr;
    int errors = 0;
    int n_compared = 0;

    initial begin
        forever #4 clk = ~clk;
    end

    hcd_side_model i_partner (.i_clk(clk), .i_rst(rst), .i_set_filled(set_f),
        .i_enable(en), .i_clf_clear(clf_clr), .o_command_status_reg(cmd),
        .o_control_reg(ctl));

    ohci_ctrl_bulk_ptrs i_dut (.i_clk(clk), .i_rst(rst), .i_mem_sel(sel),
        .i_mem_wr(wr), .i_mem_addr(addr), .i_mem_wdata(wdata),
        .o_mem_rdata(rdata), .o_mem_ack(ack), .i_init_load(init),
        .i_hcca_ctrl_head(hc_ctrl), .i_hcca_bulk_head(hc_bulk),
        .i_ed_done(done), .i_next_ed(nxt), .i_list_end(lend),
        .i_command_status_reg(cmd), .i_control_reg(ctl),
        .o_ctrl_head_addr(head), .o_ctrl_current_addr(cur),
        .o_bulk_head_addr(bulk), .o_ctrl_list_empty(empty),
        .o_clf_clear(clf_clr));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask

    task automatic acc(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        sel <= 1'b1;
        wr <= w;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        sel <= 1'b0;
        #1;
        chk({31'h0, ack}, 32'h1);
        q = rdata;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        acc(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask

    task automatic wrr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        acc(1'b1, a, d, q);
        chk(q, 32'h0);
    endtask

    task automatic ev(input logic dn, input logic le, input logic [31:0] n);
        @(posedge clk);
        done <= dn;
        lend <= le;
        nxt <= n;
        @(posedge clk);
        done <= 1'b0;
        lend <= 1'b0;
        #1;
    endtask

    task automatic endt(input string name);
        $display("test %s done", name);
    endtask

    task automatic report_and_stop;
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd(8'h20, 32'h0);
        rd(8'h24, 32'h0);
        rd(8'h28, 32'h0);
        chk({31'h0, empty}, 32'h1);
        endt("reset");
        rd(8'h2C, 32'h0);
        wrr(8'h20, 32'h12345670);
        rd(8'h20, 32'h0);
        endt("decode");
        wrr(8'h28, 32'hFFFFFFFF);
        rd(8'h28, 32'hFFFFFFF0);
        chk(bulk, 32'hFFFFFFF0);
        wrr(8'h28, 32'hA5A5A5A0);
        rd(8'h28, 32'hA5A5A5A0);
        endt("bulk head");
        @(posedge clk);
        init <= 1'b1;
        hc_ctrl <= 32'h1234567F;
        hc_bulk <= 32'h89ABCDE5;
        @(posedge clk);
        init <= 1'b0;
        #1;
        chk(head, 32'h12345670);
        chk(bulk, 32'h89ABCDE0);
        rd(8'h20, 32'h12345670);
        rd(8'h28, 32'h89ABCDE0);
        endt("init load");
        wrr(8'h24, 32'h0000C0D0);
        rd(8'h24, 32'h0000C0D0);
        @(posedge clk);
        en <= 1'b1;
        wrr(8'h24, 32'h0000FFF0);
        rd(8'h24, 32'h0000C0D0);
        chk({31'h0, empty}, 32'h0);
        endt("current write");
        ev(1'b1, 1'b0, 32'hABCD0128);
        chk(cur, 32'hABCD0120);
        repeat (5) @(posedge clk);
        #1;
        chk(cur, 32'hABCD0120);
        ev(1'b0, 1'b1, 32'h0);
        chk(cur, 32'hABCD0120);
        chk({31'h0, clf_clr}, 32'h0);
        endt("advance");
        @(posedge clk);
        set_f <= 1'b1;
        @(posedge clk);
        set_f <= 1'b0;
        ev(1'b0, 1'b1, 32'h0);
        chk(cur, 32'h12345670);
        chk({31'h0, clf_clr}, 32'h1);
        @(posedge clk);
        #1;
        chk({31'h0, clf_clr}, 32'h0);
        endt("reload");
        ev(1'b1, 1'b0, 32'h0000000F);
        chk(cur, 32'h0);
        chk({31'h0, empty}, 32'h1);
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        #1;
        chk(bulk, 32'h0);
        chk(head, 32'h0);
        rd(8'h28, 32'h0);
        endt("second reset");
        report_and_stop();
    end
endmodule // testbench
